// File: verilog/acsr_pkg.sv
package acsr_pkg;
	// ******************************
	// register offsets
	// ******************************
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_PWR = 4'h1;
	localparam logic [3:0] ADDR_PROTO = 4'h2;
	localparam logic [3:0] ADDR_LANES = 4'h3;
	localparam logic [3:0] ADDR_STROBE = 4'h4;
	localparam logic [3:0] ADDR_FORMAT = 4'h5;
	localparam logic [3:0] ADDR_AVG = 4'h6;
	localparam logic [3:0] ADDR_OFFSET = 4'h7;
	localparam int NUM_REGS = 8;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ******************************
	// field positions and masks
	// ******************************
	localparam int BIT_WIDE_READ_ZONE = 2;
	localparam int BIT_EARLY_FRAME_AVG = 1;
	localparam int BIT_HALF_REF_OFF = 5;
	localparam int BIT_SECOND_CH_OFF = 3;
	localparam int BIT_FIRST_CH_OFF = 1;
	localparam int BIT_VREF_OFF = 0;
	localparam logic [7:0] STATUS_MASK = 8'h06;
	localparam logic [7:0] PWR_MASK = 8'h2b;
	// ******************************
	// opcodes
	// ******************************
	localparam logic [3:0] OP_IDLE_ZERO = 4'h0;
	localparam logic [3:0] OP_WRITE = 4'h1;
	localparam logic [3:0] OP_READ = 4'h2;
	localparam logic [3:0] OP_SET = 4'h5;
	localparam logic [3:0] OP_CLEAR = 4'h6;
	localparam logic [3:0] OP_IDLE_ONE = 4'hf;
	localparam int FRAME_BITS = 16;
endpackage : acsr_pkg

// File: verilog/acsr_sync.sv
`timescale 1ns/1ps
module acsr_sync #(
	parameter int WIDTH = 3
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic held_r;
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					held_r <= 1'b0;
				end else if (s2_r[gi] == s3_r[gi]) begin
					held_r <= s3_r[gi];
				end
			end
			assign sync_out[gi] = held_r;
		end
	endgenerate
endmodule : acsr_sync

// File: verilog/acsr_regs.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) host leaves unlisted offsets untouched
// (R2) eight byte registers 0h-7h, reset zero
// (R3) status bits 7-3 read zero
// (R4) zone-2 wide read sets sticky bit 2
// (R5) early chip select during averaging sets bit 1
// (R6) writing one clears a sticky flag
// (R7) single reserved bits read zero
// (R8) power bits 7-6 read zero
// (R9) bit 5 powers off half reference
// (R10) bit 3 powers off second channel, buffer
// (R11) bit 1 powers off first channel, buffer
// (R12) bit 0 powers off internal reference
// (R13) 16-bit frame: opcode, address, data
// (R14) write opcode stores, read returns next frame
// (R15) set/clear opcodes by mask; others ignored
// (R16) set event wins over clearing write
module acsr_regs (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic conversion_start_pin,
	input wire logic wide_read_zone_event,
	input wire logic averaging_busy,
	output logic sdo,
	output logic half_ref_out_off,
	output logic second_channel_off,
	output logic first_channel_off,
	output logic internal_vref_off,
	output logic [7:0] readout_protocol_cfg,
	output logic [7:0] output_lane_count,
	output logic [7:0] strobe_clock_cfg,
	output logic [7:0] result_word_format,
	output logic [7:0] averaging_cfg,
	output logic [7:0] midscale_offset_select
);
	// ******************************
	// pin synchronisers
	// ******************************
	logic [3:0] pins_sync;
	logic cs_n_s;
	logic sclk_s;
	logic sdi_s;
	logic conv_s;
	// select enters inverted: reset value matches idle level, no false edge
	acsr_sync #(.WIDTH(4)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({~cs_n, sclk, sdi, conversion_start_pin}),
		.sync_out(pins_sync)
	);
	assign cs_n_s = ~pins_sync[3];
	assign sclk_s = pins_sync[2];
	assign sdi_s = pins_sync[1];
	assign conv_s = pins_sync[0];
	logic cs_n_d_r;
	logic sclk_d_r;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cs_n_d_r <= 1'b1;
			sclk_d_r <= 1'b0;
		end else begin
			cs_n_d_r <= cs_n_s;
			sclk_d_r <= sclk_s;
		end
	end
	assign cs_fall = cs_n_d_r & ~cs_n_s;
	assign cs_rise = ~cs_n_d_r & cs_n_s;
	assign sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s;
	assign sclk_fall = sclk_d_r & ~sclk_s & ~cs_n_s;
	// ******************************
	// frame shifter, mode 0: sample rising, shift falling
	// ******************************
	logic [15:0] shift_r;
	logic [4:0] bit_cnt_r;
	logic [7:0] read_buf_r;
	logic [7:0] tx_r;
	logic frame_done;
	logic [3:0] f_op;
	logic [3:0] f_addr;
	logic [7:0] f_data;
	always_ff @(posedge core_clk) begin
		if (sys_rst || cs_fall) begin
			bit_cnt_r <= '0;
			shift_r <= '0;
		end else if (sclk_rise && bit_cnt_r <= 5'(acsr_pkg::FRAME_BITS)) begin
			// a seventeenth clock spoils the count, frame refused
			shift_r <= {shift_r[14:0], sdi_s};
			bit_cnt_r <= bit_cnt_r + 5'd1;
		end
	end
	// frame counts only with full 16 bits and conversion start high at select rise
	assign frame_done = cs_rise && bit_cnt_r == 5'(acsr_pkg::FRAME_BITS)
		&& conv_s; // R13
	assign f_op = shift_r[15:12];
	assign f_addr = shift_r[11:8];
	assign f_data = shift_r[7:0];
	// ******************************
	// register array
	// ******************************
	logic [7:0] regs_r [acsr_pkg::NUM_REGS];
	logic [7:0] reg_mask [acsr_pkg::NUM_REGS];
	logic in_map;
	assign in_map = f_addr < 4'(acsr_pkg::NUM_REGS); // R2
	genvar gi;
	generate
		for (gi = 0; gi < acsr_pkg::NUM_REGS; gi++) begin : g_reg
			if (gi == 0) begin : g_status
				assign reg_mask[gi] = acsr_pkg::STATUS_MASK; // R3 R7
			end else if (gi == 1) begin : g_pwr
				assign reg_mask[gi] = acsr_pkg::PWR_MASK; // R7 R8
			end else begin : g_plain
				assign reg_mask[gi] = 8'hff;
			end
		end
	endgenerate
	logic hit;
	logic [7:0] cur;
	always_comb begin
		hit = frame_done && in_map;
		cur = regs_r[f_addr[2:0]];
	end
	// status: sticky flags
	logic [7:0] evt;
	logic [7:0] clr;
	always_comb begin
		evt = '0;
		evt[acsr_pkg::BIT_WIDE_READ_ZONE] = wide_read_zone_event; // R4
		evt[acsr_pkg::BIT_EARLY_FRAME_AVG] = cs_fall & averaging_busy; // R5
		clr = '0;
		if (hit && f_addr == acsr_pkg::ADDR_STATUS) begin
			if (f_op == acsr_pkg::OP_WRITE || f_op == acsr_pkg::OP_CLEAR) begin
				clr = f_data; // R6
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			regs_r[0] <= acsr_pkg::REG_RESET; // R2
		end else begin
			// set wins over clear
			regs_r[0] <= ((regs_r[0] & ~clr) | evt) & acsr_pkg::STATUS_MASK; // R16
		end
	end
	generate
		for (gi = 1; gi < acsr_pkg::NUM_REGS; gi++) begin : g_cfg
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					regs_r[gi] <= acsr_pkg::REG_RESET; // R2
				end else if (hit && f_addr[2:0] == 3'(gi)) begin
					unique case (f_op)
						acsr_pkg::OP_WRITE: regs_r[gi] <= f_data & reg_mask[gi]; // R14
						acsr_pkg::OP_SET: regs_r[gi] <= (cur | f_data) & reg_mask[gi]; // R15
						acsr_pkg::OP_CLEAR: regs_r[gi] <= cur & ~f_data; // R15
						default: regs_r[gi] <= regs_r[gi];
					endcase
				end
			end
		end
	endgenerate
	// ******************************
	// readback: latched at read frame end, shifted out next frame
	// ******************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			read_buf_r <= '0;
		end else if (frame_done) begin
			read_buf_r <= (f_op == acsr_pkg::OP_READ && in_map) ? cur : 8'h00; // R14
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_r <= '0;
			sdo <= 1'b0;
		end else if (cs_fall) begin
			tx_r <= {read_buf_r[6:0], 1'b0};
			sdo <= read_buf_r[7]; // R14
		end else if (sclk_fall) begin
			tx_r <= {tx_r[6:0], 1'b0};
			sdo <= tx_r[7];
		end
	end
	// ******************************
	// outputs from flip-flops
	// ******************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			half_ref_out_off <= 1'b0;
			second_channel_off <= 1'b0;
			first_channel_off <= 1'b0;
			internal_vref_off <= 1'b0;
			readout_protocol_cfg <= '0;
			output_lane_count <= '0;
			strobe_clock_cfg <= '0;
			result_word_format <= '0;
			averaging_cfg <= '0;
			midscale_offset_select <= '0;
		end else begin
			half_ref_out_off <= regs_r[1][acsr_pkg::BIT_HALF_REF_OFF]; // R9
			second_channel_off <= regs_r[1][acsr_pkg::BIT_SECOND_CH_OFF]; // R10
			first_channel_off <= regs_r[1][acsr_pkg::BIT_FIRST_CH_OFF]; // R11
			internal_vref_off <= regs_r[1][acsr_pkg::BIT_VREF_OFF]; // R12
			readout_protocol_cfg <= regs_r[2];
			output_lane_count <= regs_r[3];
			strobe_clock_cfg <= regs_r[4];
			result_word_format <= regs_r[5];
			averaging_cfg <= regs_r[6];
			midscale_offset_select <= regs_r[7];
		end
	end
	// ******************************
	// checks
	// ******************************
	sequence pwr_write_s;
		hit && f_addr == acsr_pkg::ADDR_PWR && f_op == acsr_pkg::OP_WRITE;
	endsequence
	status_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		(regs_r[0] & ~acsr_pkg::STATUS_MASK) == 8'h00)
		else $error("status reserved bits set");
	pwr_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
		(regs_r[1] & ~acsr_pkg::PWR_MASK) == 8'h00)
		else $error("power reserved bits set");
	zone_flag_set_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		wide_read_zone_event |=> regs_r[0][2])
		else $error("zone flag not set");
	avg_flag_set_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		cs_fall && averaging_busy |=> regs_r[0][1])
		else $error("average flag not set");
	sticky_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		regs_r[0][2] && !clr[2] |=> regs_r[0][2])
		else $error("sticky flag lost");
	sticky_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
		clr[1] && !evt[1] |=> !regs_r[0][1])
		else $error("flag not cleared");
	pwr_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
		pwr_write_s |=> regs_r[1] == ($past(f_data) & acsr_pkg::PWR_MASK)
		##1 half_ref_out_off == regs_r[1][5])
		else $error("power write wrong");
	chan_out_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
		##1 second_channel_off == $past(regs_r[1][3])
		&& first_channel_off == $past(regs_r[1][1])
		&& internal_vref_off == $past(regs_r[1][0]))
		else $error("power output mismatch");
	idle_op_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
		hit && f_addr == acsr_pkg::ADDR_PROTO && f_op != acsr_pkg::OP_WRITE
		&& f_op != acsr_pkg::OP_SET && f_op != acsr_pkg::OP_CLEAR
		|=> $stable(regs_r[2]))
		else $error("idle opcode changed register");
endmodule : acsr_regs

// File: tb/acsr_host.sv
`timescale 1ns/1ps
module acsr_host (
	input wire logic core_clk,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	output logic conversion_start_pin,
	input wire logic sdo
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		conversion_start_pin = 1'b1;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : gap
	// ******************************
	// one command frame, clock idles low
	// ******************************
	task automatic frame(input logic [15:0] cmd, input logic conv, output logic [15:0] got);
		conversion_start_pin = conv;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			gap(10);
			sdi = cmd[i];
			got[i] = sdo;
			gap(10);
			sclk = 1'b1;
			gap(10);
			sclk = 1'b0;
		end
		gap(10);
		cs_n = 1'b1;
		sdi = ~sdi;
		gap(12);
		conversion_start_pin = 1'b1;
	endtask : frame
endmodule : acsr_host

// File: tb/acsr_regs_tb_top.sv
`timescale 1ns/1ps
module acsr_regs_tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cs_n, sclk, sdi, conversion_start_pin, sdo;
	logic wide_read_zone_event = 1'b0;
	logic averaging_busy = 1'b0;
	logic half_ref_out_off, second_channel_off, first_channel_off, internal_vref_off;
	logic [47:0] cfg_bus;
	logic [3:0] ops [5] = '{4'h0, 4'h3, 4'h4, 4'h7, 4'hf};
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	acsr_host acsr_host_inst (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.conversion_start_pin(conversion_start_pin), .sdo(sdo));
	acsr_regs acsr_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
		.sclk(sclk), .sdi(sdi), .conversion_start_pin(conversion_start_pin),
		.wide_read_zone_event(wide_read_zone_event), .averaging_busy(averaging_busy),
		.sdo(sdo), .half_ref_out_off(half_ref_out_off),
		.second_channel_off(second_channel_off), .first_channel_off(first_channel_off),
		.internal_vref_off(internal_vref_off), .readout_protocol_cfg(cfg_bus[7:0]),
		.output_lane_count(cfg_bus[15:8]), .strobe_clock_cfg(cfg_bus[23:16]),
		.result_word_format(cfg_bus[31:24]), .averaging_cfg(cfg_bus[39:32]),
		.midscale_offset_select(cfg_bus[47:40]));
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			$display("unexpected at %0t: run hung", $time);
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [7:0] d,
		input logic conv = 1'b1);
		logic [15:0] junk;
		acsr_host_inst.frame({op, a, d}, conv, junk);
	endtask : cmd
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [15:0] got;
		cmd(acsr_pkg::OP_READ, a, 8'h00);
		acsr_host_inst.frame({acsr_pkg::OP_IDLE_ZERO, 12'h000}, 1'b1, got);
		chk(got[15:8], exp, "readback");
	endtask : rd_chk
	function automatic logic [7:0] flags();
		return {4'h0, half_ref_out_off, second_channel_off, first_channel_off, internal_vref_off};
	endfunction : flags
	// ******************************
	// main sequence
	// ******************************
	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		acsr_host_inst.gap(4);
		for (int a = 0; a < 8; a++) rd_chk(a[3:0], 8'h00);
		chk(flags(), 8'h00, "power flags");
		$display("test reset values done");
		cmd(acsr_pkg::OP_WRITE, 4'h0, 8'h06);
		cmd(acsr_pkg::OP_WRITE, 4'h1, 8'h2b);
		for (int a = 2; a < 8; a++) cmd(acsr_pkg::OP_WRITE, a[3:0], 8'hff);
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h1, 8'h2b);
		for (int a = 2; a < 8; a++) rd_chk(a[3:0], 8'hff);
		for (int i = 0; i < 6; i++) chk(cfg_bus[8*i+:8], 8'hff, "config port");
		chk(flags(), 8'h0f, "power flags");
		$display("test write all done");
		cmd(acsr_pkg::OP_CLEAR, 4'h1, 8'h0a);
		rd_chk(4'h1, 8'h21);
		chk(flags(), 8'h09, "power flags");
		cmd(acsr_pkg::OP_SET, 4'h1, 8'h0a);
		rd_chk(4'h1, 8'h2b);
		for (int i = 0; i < 5; i++) cmd(ops[i], 4'h2, 8'h00);
		cmd(acsr_pkg::OP_READ, 4'h9, 8'h00);
		cmd(acsr_pkg::OP_WRITE, 4'h2, 8'h00, 1'b0);
		rd_chk(4'h2, 8'hff);
		rd_chk(4'h1, 8'h2b);
		$display("test set clear refuse done");
		wide_read_zone_event = 1'b1;
		acsr_host_inst.gap(1);
		wide_read_zone_event = 1'b0;
		rd_chk(4'h0, 8'h04);
		averaging_busy = 1'b1;
		cmd(acsr_pkg::OP_IDLE_ZERO, 4'h0, 8'h00);
		averaging_busy = 1'b0;
		rd_chk(4'h0, 8'h06);
		cmd(acsr_pkg::OP_WRITE, 4'h0, 8'h00);
		rd_chk(4'h0, 8'h06);
		cmd(acsr_pkg::OP_WRITE, 4'h0, 8'h04);
		rd_chk(4'h0, 8'h02);
		wide_read_zone_event = 1'b1;
		cmd(acsr_pkg::OP_CLEAR, 4'h0, 8'h06);
		wide_read_zone_event = 1'b0;
		rd_chk(4'h0, 8'h04);
		cmd(acsr_pkg::OP_CLEAR, 4'h0, 8'h04);
		rd_chk(4'h0, 8'h00);
		$display("test sticky status done");
		end_of_test();
	end
endmodule : acsr_regs_tb_top
